// ### rtl/card_cmd_decoder.sv
// Purpose: serial command decoder and readback for a dual card interface
// Assumes: serial pins and card pins are synchronous to mclk
// Notes:   card a is index 0, card b is index 1
//
// Functional notes
// - card reset follows b4 except addresses 101, 100 and async commands with b6 not equal strap
// - reset follows b4 while byte shifts in
// - async command b3:b2 clock, b1:b0 supply
// - clock field: low, pass, divide two, four
// - supply field: off, 1.8, 3.0, 5.0 V
// - sync addresses drive reset, clock, io, aux
// - config codes set detect, serial mode, slope
// - undefined config codes have no effect
// - address 100 decoded and ignored
// - b5 selects card a or b
// - other card keeps its supply and clock
// - configuration applies to both cards
// - async command needs b6 equal strap
// - readback shifts out during command transfer
// - readback launched rising special, falling normal
// - readback holds detect, io, aux, supply good
// - readback is previous transfer's sampled state
// - command register updates only while selected
// - normal mode detect bit means card present
// - reset defaults: open switch, off, slow, special
`default_nettype none
module card_cmd_decoder
	import card_cmd_pkg::*;
(
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             resetn,
	// serial command port
	input  wire logic             sclk,
	input  wire logic             cs_n,
	input  wire logic             mosi,
	output var  logic             miso_out,
	output var  logic             miso_oe,
	// device strap and card master clock
	input  wire logic             device_address_strap,
	input  wire logic             clk_in,
	// card status inputs
	input  wire logic [1:0]       card_detect_in,
	input  wire logic [1:0]       card_io_in,
	input  wire logic [1:0]       card_aux_first_in,
	input  wire logic [1:0]       card_aux_second_in,
	input  wire logic [1:0]       supply_good_flag,
	// card outputs
	output var  logic [1:0]       card_reset_out,
	output var  logic [1:0]       card_clock_out,
	output var  logic [1:0][1:0]  card_supply_level,
	output var  logic [1:0]       card_io_out,
	output var  logic [1:0]       card_io_oe,
	output var  logic [1:0]       card_aux_first_out,
	output var  logic [1:0]       card_aux_first_oe,
	output var  logic [1:0]       card_aux_second_out,
	output var  logic [1:0]       card_aux_second_oe,
	// global configuration
	output var  logic             fast_edge_slope,
	output var  logic             detect_normally_closed,
	output var  logic             serial_normal_mode
);

	// ****************************************
	// serial edge detection
	// ****************************************
	logic                         sclk_q;
	logic                         cs_q;
	logic                         sclk_rise;
	logic                         sclk_fall;
	logic                         cs_fall;
	logic                         cs_rise;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
		end else begin
			sclk_q <= sclk;
			cs_q   <= cs_n;
		end
	end

	assign sclk_rise = sclk & ~sclk_q & ~cs_n;
	assign sclk_fall = ~sclk & sclk_q & ~cs_n;
	assign cs_fall   = ~cs_n & cs_q;
	assign cs_rise   = cs_n & ~cs_q;

	// ****************************************
	// command shift register
	// ****************************************
	logic [CMD_BITS-1:0]          cmd;
	logic [3:0]                   bit_cnt;
	logic [2:0]                   early_addr;
	logic                         early_strap_ok;
	logic                         rst_point;
	logic                         done;
	logic [2:0]                   addr;
	logic                         sel;
	logic                         strap_ok;
	logic                         is_async;
	logic                         is_sync;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cmd     <= '0;
			bit_cnt <= '0;
		end else if (cs_n) begin
			bit_cnt <= '0;
		end else if (sclk_rise && bit_cnt != CMD_FULL) begin
			cmd     <= {cmd[CMD_BITS-2:0], mosi};
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	assign early_addr     = cmd[2:0];
	assign early_strap_ok = early_addr[1] == device_address_strap;
	assign rst_point      = sclk_rise && bit_cnt == CMD_RST_BIT;
	assign done           = cs_rise && bit_cnt == CMD_FULL;
	assign addr           = cmd[ADDR_HI:ADDR_LO];
	assign sel            = cmd[SEL_POS];
	assign strap_ok       = cmd[STRAP_POS] == device_address_strap;
	assign is_async       = ~addr[2];
	assign is_sync        = addr[2:1] == ADDR_SYNC_TOP;

	// ****************************************
	// global configuration
	// ****************************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			fast_edge_slope        <= 1'b0;
			detect_normally_closed <= 1'b0;
			serial_normal_mode     <= 1'b0;
		end else if (done && addr == ADDR_CONFIG) begin
			case (cmd[2:0])
				CFG_DET_NO:  detect_normally_closed <= 1'b0;
				CFG_DET_NC:  detect_normally_closed <= 1'b1;
				CFG_SPECIAL: serial_normal_mode     <= 1'b0;
				CFG_NORMAL:  serial_normal_mode     <= 1'b1;
				CFG_SLOW:    fast_edge_slope        <= 1'b0;
				CFG_FAST:    fast_edge_slope        <= 1'b1;
				default:     fast_edge_slope        <= fast_edge_slope;
			endcase
		end
	end

	// ****************************************
	// master clock divider
	// ****************************************
	logic                         clk_in_q;
	logic [1:0]                   div_cnt;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			clk_in_q <= 1'b0;
			div_cnt  <= '0;
		end else begin
			clk_in_q <= clk_in;
			if (clk_in && !clk_in_q) begin
				div_cnt <= div_cnt + 2'h1;
			end
		end
	end

	// ****************************************
	// per card state
	// ****************************************
	logic [1:0][1:0]              clk_sel;
	logic [1:0]                   sync_mode;
	logic [1:0]                   sync_clk;

	for (genvar c = 0; c < 2; c++) begin : g_card
		logic hit;

		assign hit = done && sel == 1'(c);

		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				card_reset_out[c] <= 1'b0;
			end else if (rst_point && early_addr[0] == 1'(c)
				&& early_addr[2:1] != ADDR_IGNORE[2:1]
				&& (early_addr[2] || early_strap_ok)) begin
				card_reset_out[c] <= mosi;
			end
		end

		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				clk_sel[c]           <= CK_LOW;
				card_supply_level[c] <= VCC_OFF;
				sync_mode[c]         <= 1'b0;
			end else if (hit && is_async && strap_ok) begin
				clk_sel[c]           <= cmd[CLK_HI:CLK_LO];
				card_supply_level[c] <= cmd[VCC_HI:VCC_LO];
				sync_mode[c]         <= 1'b0;
			end else if (hit && is_sync) begin
				sync_mode[c]         <= 1'b1;
			end
		end

		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				sync_clk[c]            <= 1'b0;
				card_io_out[c]         <= 1'b0;
				card_aux_first_out[c]  <= 1'b0;
				card_aux_second_out[c] <= 1'b0;
			end else if (hit && is_sync) begin
				sync_clk[c]            <= cmd[SCLK_POS];
				card_io_out[c]         <= cmd[SIO_POS];
				card_aux_first_out[c]  <= cmd[SAUX1_POS];
				card_aux_second_out[c] <= cmd[SAUX2_POS];
			end
		end

		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				card_io_oe[c]         <= 1'b0;
				card_aux_first_oe[c]  <= 1'b0;
				card_aux_second_oe[c] <= 1'b0;
				card_clock_out[c]     <= 1'b0;
			end else begin
				card_io_oe[c]         <= sync_mode[c];
				card_aux_first_oe[c]  <= sync_mode[c];
				card_aux_second_oe[c] <= sync_mode[c];
				if (sync_mode[c]) begin
					card_clock_out[c] <= sync_clk[c];
				end else begin
					case (clk_sel[c])
						CK_LOW:  card_clock_out[c] <= 1'b0;
						CK_DIV1: card_clock_out[c] <= clk_in;
						CK_DIV2: card_clock_out[c] <= div_cnt[0];
						CK_DIV4: card_clock_out[c] <= div_cnt[1];
						default: card_clock_out[c] <= 1'b0;
					endcase
				end
			end
		end
	end

	// ****************************************
	// readback snapshot and shifter
	// ****************************************
	logic [4:0]                   snap;
	logic [4:0]                   next_snap;
	logic [CMD_BITS-1:0]          tx;
	logic                         esel;
	logic                         present;

	assign esel    = early_addr[0];
	assign present = card_detect_in[esel] ^ detect_normally_closed;

	always_comb begin
		next_snap    = '0;
		next_snap[4] = serial_normal_mode ? present : card_detect_in[esel];
		next_snap[3] = card_io_in[esel];
		next_snap[2] = card_aux_first_in[esel];
		next_snap[1] = card_aux_second_in[esel];
		next_snap[0] = supply_good_flag[esel];
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			snap <= RB_RESET;
		end else if (rst_point) begin
			snap <= next_snap;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tx       <= '0;
			miso_out <= 1'b0;
			miso_oe  <= 1'b0;
		end else begin
			miso_oe <= ~cs_n;
			if (cs_fall) begin
				tx       <= {RB_PAD, snap} << 1;
				miso_out <= RB_PAD[2];
			end else if (serial_normal_mode ? sclk_fall : sclk_rise) begin
				tx       <= tx << 1;
				miso_out <= tx[CMD_BITS-1];
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	reset_follow_b4_a: assert property (
		rst_point && early_addr[2:1] != ADDR_IGNORE[2:1] && early_addr[2]
		|=> card_reset_out[$past(esel)] == $past(mosi))
		else $error("card reset did not follow b4");

	ignore_addr_100_a: assert property (
		done && addr == ADDR_IGNORE
		|=> $stable(clk_sel) && $stable(card_supply_level) && $stable(sync_mode))
		else $error("address 100 changed settings");

	async_supply_set_a: assert property (
		done && is_async && strap_ok
		|=> card_supply_level[$past(sel)] == $past(cmd[VCC_HI:VCC_LO])
		&& clk_sel[$past(sel)] == $past(cmd[CLK_HI:CLK_LO]))
		else $error("async command not applied");

	other_card_kept_a: assert property (
		done && is_async
		|=> card_supply_level[~$past(sel)] == $past(card_supply_level[~sel]))
		else $error("unselected card supply disturbed");

	strap_mismatch_a: assert property (
		done && is_async && !strap_ok
		|=> $stable(card_supply_level) && $stable(clk_sel))
		else $error("command for other device accepted");

	config_slope_a: assert property (
		done && addr == ADDR_CONFIG && cmd[2:0] == CFG_FAST
		|=> fast_edge_slope ##1 fast_edge_slope)
		else $error("fast slope not set");

	config_undef_a: assert property (
		done && addr == ADDR_CONFIG && cmd[2:0] > CFG_FAST
		|=> $stable(fast_edge_slope) && $stable(serial_normal_mode)
		&& $stable(detect_normally_closed))
		else $error("undefined config code had effect");

	readback_pad_a: assert property (
		cs_fall |=> miso_oe && !miso_out ##1 (cs_n || miso_oe))
		else $error("readback not started at select");

	snapshot_good_a: assert property (
		rst_point |=> snap[0] == $past(supply_good_flag[esel]))
		else $error("supply good not captured");

	deselect_hold_a: assert property (
		cs_n && cs_q |=> $stable(cmd) && bit_cnt == 4'h0)
		else $error("command changed while deselected");

endmodule
`default_nettype wire

// ### rtl/card_cmd_pkg.sv
// Purpose: shared constants of the dual card command decoder
// Assumes: command byte shifted most significant bit first
// Notes:   field positions index the eight-bit command byte
`default_nettype none
package card_cmd_pkg;
	// ****************************************
	// command layout
	// ****************************************
	localparam int          CMD_BITS      = 8;
	localparam logic [3:0]  CMD_FULL      = 4'h8;
	localparam logic [3:0]  CMD_RST_BIT   = 4'h3;   // count when b4 is on the wire
	localparam int          ADDR_HI       = 7;
	localparam int          ADDR_LO       = 5;
	localparam int          STRAP_POS     = 6;
	localparam int          SEL_POS       = 5;
	localparam int          RST_POS       = 4;
	localparam int          CLK_HI        = 3;
	localparam int          CLK_LO        = 2;
	localparam int          VCC_HI        = 1;
	localparam int          VCC_LO        = 0;
	localparam int          SCLK_POS      = 3;
	localparam int          SIO_POS       = 2;
	localparam int          SAUX1_POS     = 1;
	localparam int          SAUX2_POS     = 0;
	// ****************************************
	// address codes
	// ****************************************
	localparam logic [2:0]  ADDR_IGNORE   = 3'h4;
	localparam logic [2:0]  ADDR_CONFIG   = 3'h5;
	localparam logic [1:0]  ADDR_SYNC_TOP = 2'h3;
	// ****************************************
	// configuration low bits
	// ****************************************
	localparam logic [2:0]  CFG_DET_NO    = 3'h0;
	localparam logic [2:0]  CFG_DET_NC    = 3'h1;
	localparam logic [2:0]  CFG_SPECIAL   = 3'h2;
	localparam logic [2:0]  CFG_NORMAL    = 3'h3;
	localparam logic [2:0]  CFG_SLOW      = 3'h4;
	localparam logic [2:0]  CFG_FAST      = 3'h5;
	// ****************************************
	// card clock field and supply field
	// ****************************************
	localparam logic [1:0]  CK_LOW        = 2'h0;
	localparam logic [1:0]  CK_DIV1       = 2'h1;
	localparam logic [1:0]  CK_DIV2       = 2'h2;
	localparam logic [1:0]  CK_DIV4       = 2'h3;
	localparam logic [1:0]  VCC_OFF       = 2'h0;   // 01 1.8 V, 10 3.0 V, 11 5.0 V
	// ****************************************
	// readback byte
	// ****************************************
	localparam logic [2:0]  RB_PAD        = 3'h0;
	localparam logic [4:0]  RB_RESET      = 5'h00;
endpackage
`default_nettype wire

// ### dv/spi_host_model.sv
// Purpose: serial bus master model driving the command decoder
// Assumes: all bus lines change on mclk falling edges
// Notes:   readback sampled before each serial clock rise and late in its high phase
`default_nettype none
module spi_host_model (
	// clock
	input  wire logic mclk,
	// serial bus
	output var  logic sclk,
	output var  logic cs_n,
	output var  logic mosi,
	input  wire logic miso_out,
	input  wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end
	// serial clock stands low outside frames; sel low keeps the device deselected
	task automatic xfer(input logic [7:0] cmd, input int nbits, input logic sel,
		output logic [7:0] rb, output logic [7:0] rbh);
		rb = 8'h00;
		rbh = 8'h00;
		@(negedge mclk);
		cs_n = ~sel;
		repeat (2) @(negedge mclk);
		for (int i = 0; i < nbits; i++) begin
			mosi = cmd[7 - (i % 8)];
			repeat (3) @(negedge mclk);
			rb = {rb[6:0], miso_oe ? miso_out : 1'bx};
			sclk = 1'b1;
			repeat (3) @(negedge mclk);
			rbh = {rbh[6:0], miso_oe ? miso_out : 1'bx};
			sclk = 1'b0;
		end
		repeat (2) @(negedge mclk);
		cs_n = 1'b1;
		mosi = ~mosi;
		rb = rb & 8'h1F;
		repeat (2) @(negedge mclk);
	endtask
endmodule
`default_nettype wire

// ### dv/dual_card_spi_command_decoder_tb_top.sv
// Purpose: self-checking bench for the dual card command decoder
// Assumes: host model drives the serial bus on mclk falling edges
// Notes:   card clock rates checked by counting rises over 64 cycles
`default_nettype none
module dual_card_spi_command_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// design, host and model state
	// ****************************************
	logic            mclk, resetn, sclk, cs_n, mosi, miso_out, miso_oe;
	logic            device_address_strap, clk_in;
	logic            fast_edge_slope, detect_normally_closed, serial_normal_mode;
	logic [1:0]      card_detect_in, card_io_in, card_aux_first_in, card_aux_second_in;
	logic [1:0]      supply_good_flag, card_reset_out, card_clock_out, card_io_out;
	logic [1:0]      card_io_oe, card_aux_first_out, card_aux_first_oe;
	logic [1:0]      card_aux_second_out, card_aux_second_oe;
	logic [1:0][1:0] card_supply_level, m_ck, m_vcc;
	logic [1:0]      m_rst, m_sync, m_sck, m_io, m_a1, m_a2;
	logic            m_fast, m_nc, m_norm;
	logic [7:0]      m_rb;
	int              error_cnt = 0;
	int              num_checks = 0;

	card_cmd_decoder uut (.mclk, .resetn, .sclk, .cs_n, .mosi, .miso_out, .miso_oe,
		.device_address_strap, .clk_in, .card_detect_in, .card_io_in, .card_aux_first_in,
		.card_aux_second_in, .supply_good_flag, .card_reset_out, .card_clock_out,
		.card_supply_level, .card_io_out, .card_io_oe, .card_aux_first_out,
		.card_aux_first_oe, .card_aux_second_out, .card_aux_second_oe, .fast_edge_slope,
		.detect_normally_closed, .serial_normal_mode);
	spi_host_model host (.mclk, .sclk, .cs_n, .mosi, .miso_out, .miso_oe);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always #20 clk_in = ~clk_in;

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic miss(input string what);
		error_cnt++;
		$display("unexpected at %0t: %s", $time, what);
	endtask
	task automatic cmp_state(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp)
			miss(what);
	endtask
	task automatic cmp_rb(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
			miss($sformatf("readback %h expected %h", got, exp));
	endtask

	function automatic void apply(input logic [7:0] cmd);
		logic c;
		c = cmd[5];
		if (!cmd[7] && cmd[6] == device_address_strap) begin
			m_ck[c] = cmd[3:2];
			m_vcc[c] = cmd[1:0];
			m_sync[c] = 1'b0;
		end else if (cmd[7:6] == 2'h3) begin
			{m_sck[c], m_io[c], m_a1[c], m_a2[c]} = cmd[3:0];
			m_sync[c] = 1'b1;
		end else if (cmd[7:5] == 3'h5) begin
			case (cmd[2:1])
				2'h0: m_nc = cmd[0];
				2'h1: m_norm = cmd[0];
				2'h2: m_fast = cmd[0];
				default: ;
			endcase
		end
	endfunction

	task automatic check_state;
		logic [31:0] got;
		logic [1:0]  last;
		int          n[2];
		int          e;
		got = 32'({card_reset_out, card_supply_level, card_io_oe, card_aux_first_oe,
			card_aux_second_oe});
		cmp_state(got, 32'({m_rst, m_vcc, {3{m_sync}}}), "reset, supply or enables");
		got = 32'({card_io_out & card_io_oe, card_aux_first_out & card_aux_first_oe,
			card_aux_second_out & card_aux_second_oe});
		cmp_state(got, 32'({m_io & m_sync, m_a1 & m_sync, m_a2 & m_sync}), "sync lines");
		got = 32'({fast_edge_slope, detect_normally_closed, serial_normal_mode});
		cmp_state(got, 32'({m_fast, m_nc, m_norm}), "configuration");
		last = card_clock_out;
		n = '{0, 0};
		repeat (64) begin
			@(negedge mclk);
			for (int c = 0; c < 2; c++)
				n[c] += int'(card_clock_out[c] & ~last[c]);
			last = card_clock_out;
		end
		for (int c = 0; c < 2; c++) begin
			e = (m_sync[c] || m_ck[c] == 2'h0) ? 0 : 32 >> m_ck[c];
			cmp_state(32'(n[c] >= e - 1 && n[c] <= e + 1), 32'h1, "clock rate");
			if (e == 0)
				cmp_state(32'(card_clock_out[c]), 32'(m_sync[c] & m_sck[c]), "clock level");
		end
	endtask

	task automatic do_reset;
		resetn = 1'b0;
		repeat (20) @(negedge mclk);
		resetn = 1'b1;
		{m_rst, m_sync, m_sck, m_io, m_a1, m_a2, m_ck, m_vcc, m_fast, m_nc, m_norm, m_rb} = '0;
		repeat (2) @(negedge mclk);
		check_state;
	endtask

	task automatic run(input logic [7:0] cmd, input int nbits = 8, input logic sel = 1'b1);
		logic [7:0] rb, rbh, exp;
		logic       c, nm;
		c = cmd[5];
		nm = m_norm;
		exp = m_rb;
		{card_detect_in, card_io_in, card_aux_first_in, card_aux_second_in,
			supply_good_flag} = 10'($urandom);
		if (sel && nbits >= 4) begin
			m_rb = {3'h0, card_detect_in[c] ^ (m_norm & m_nc), card_io_in[c],
				card_aux_first_in[c], card_aux_second_in[c], supply_good_flag[c]};
			if (cmd[7:6] != 2'h2 && (cmd[7] || cmd[6] == device_address_strap))
				m_rst[c] = cmd[4];
		end
		host.xfer(cmd, nbits, sel, rb, rbh);
		if (sel && nbits >= 8)
			apply(cmd);
		if (sel && nbits == 8) begin
			cmp_rb(rb, exp);
			cmp_rb(nm ? rbh & 8'h1F : {3'h0, rbh[4:1], 1'b0}, nm ? rb : {3'h0, rb[3:0], 1'b0});
		end
		repeat (2) @(negedge mclk);
		check_state;
	endtask

	initial begin
		resetn = 1'b0;
		clk_in = 1'b0;
		device_address_strap = 1'b0;
		{card_detect_in, card_io_in, card_aux_first_in, card_aux_second_in,
			supply_good_flag} = 10'h000;
		void'($urandom(96339));
		do_reset;
		$display("test reset done");
		for (int i = 0; i < 64; i++) begin
			device_address_strap = i[5];
			run({1'b0, (i % 5 == 0) ? ~i[5] : i[5], i[0], 1'($urandom), i[4:1]});
		end
		$display("test async programming done");
		for (int i = 0; i < 16; i++) begin
			run({3'h5, 2'($urandom), i[2:0]});
			run(8'($urandom));
			run({3'h4, 5'($urandom)});
		end
		$display("test configuration done");
		for (int i = 0; i < 64; i++)
			run({2'h3, i[5:0]});
		$display("test sync card bits done");
		for (int i = 0; i < 8; i++)
			run(8'($urandom), 3 + i, i != 5);
		$display("test short and deselected transfers done");
		do_reset;
		$display("test second reset done");
		test_done;
	end

	initial begin
		#1000000;
		miss("timeout");
		test_done;
	end
endmodule
`default_nettype wire
